//--- tb/fpec_cpu_model.sv
// fpec_cpu_model: bus master standing in for the cpu core on the register bus
// assumes: one clock, the slave answers by dropping waitrequest
`timescale 1ns/1ns
module fpec_cpu_model (
  input wire logic ref_clk,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  output fpec_pkg::fpec_addr_t avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  import fpec_pkg::*;
  // idle bus at time zero
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
  end
  // one access: request held until waitrequest is sampled low, data taken at that edge
  task automatic access(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released lines show the inverse, never a stale value
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule

//--- tb/tb.sv
// tb: self-checking bench of the flash program/erase control
// assumes: reference model below mirrors the cell array with integers
`timescale 1ns/1ns
`include "fpec_defs.svh"
module tb;
  import fpec_pkg::*;
  localparam int BOOT0 = 56; // first location of the boot block
  logic ref_clk = 1'b0;
  logic nrst, stopMode, waitMode, specialModeLine, progSupplyOk;
  fpec_addr_t avs_address;
  logic avs_read, avs_write, avs_waitrequest, hvApplied, wakeDelaySel;
  logic [31:0] avs_writedata, avs_readdata, q, d;
  logic [7:0] testBits;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 32'h5D5F9B3F;
  int mem [64]; // model of the cells
  always #5 ref_clk = ~ref_clk;
  fpec_top fpec_top_inst (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .stopMode(stopMode), .waitMode(waitMode),
    .specialModeLine(specialModeLine), .progSupplyOk(progSupplyOk), .hvApplied(hvApplied),
    .wakeDelaySel(wakeDelaySel), .testBits(testBits));
  fpec_cpu_model fpec_cpu_model_inst (.ref_clk(ref_clk), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    fpec_cpu_model_inst.access(1'b0, a, v, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    fpec_cpu_model_inst.access(1'b1, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  // whole array against the model
  task automatic check_all();
    for (int i = 0; i < 64; i++) rchk(8'h80 + 8'(i), 32'(mem[i]));
  endtask
  // full program or erase pass of two pulses, model updated alike
  task automatic op(input int idx, input logic [31:0] v, input bit ers, input bit bp);
    logic [7:0] c;
    c = 8'h04 | (ers ? 8'h02 : 8'h00) | (bp ? 8'h08 : 8'h00);
    wr(`FPEC_CTRL_OFS, 32'(c));
    wr(8'h80 + 8'(idx), v);
    // one pulse, then one margin pulse; hv held while software times the pulse
    repeat (2) begin
      wr(`FPEC_CTRL_OFS, 32'(c | 8'h01));
      repeat (4) @(posedge ref_clk);
      wr(`FPEC_CTRL_OFS, 32'(c));
    end
    rchk(`FPEC_STAT_OFS, 32'h2);
    wr(`FPEC_CTRL_OFS, 32'h08);
    for (int i = 0; i < 64; i++) begin
      if (!(bp && i >= BOOT0)) begin
        if (ers) mem[i] = 32'hFFFF;
        else if (i == idx) mem[i] = mem[i] & int'(v[15:0]);
      end
    end
  endtask
  // verdict, also reached by the watchdog
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog, far above the few thousand cycles the sequence needs
  initial begin
    #500000;
    mismatches++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    stopMode = 1'b0;
    waitMode = 1'b0;
    specialModeLine = 1'b0;
    progSupplyOk = 1'b1;
    for (int i = 0; i < 64; i++) mem[i] = 32'hFFFF;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rchk(`FPEC_CTRL_OFS, 32'h48);
    wr(8'h80, 32'h1234); // latch write refused with latch clear
    check_all();
    rchk(8'h40, 32'h0);
    // boot protect kept set in these writes so only hv and latch can move
    wr(`FPEC_CTRL_OFS, 32'h09);
    rchk(`FPEC_CTRL_OFS, 32'h48);
    wr(`FPEC_CTRL_OFS, 32'h0D);
    rchk(`FPEC_CTRL_OFS, 32'h4C);
    wr(`FPEC_CTRL_OFS, 32'h0D);
    rchk(`FPEC_CTRL_OFS, 32'h4C);
    wr(`FPEC_CTRL_OFS, 32'h08);
    // program with interlocks probed while high voltage is on
    d = 32'($random(seed)) & 32'h0000_FFFF;
    wr(`FPEC_CTRL_OFS, 32'h04);
    wr(8'h85, d);
    wr(8'h86, 32'h0000_0000);
    rchk(`FPEC_CTRL_OFS, 32'h64);
    wr(`FPEC_CTRL_OFS, 32'h05);
    #1 chk(32'(hvApplied), 32'h1);
    rchk(8'h85, 32'h0);
    // under hv erase and boot bits are frozen while hv stays on
    wr(`FPEC_CTRL_OFS, 32'h0F);
    rchk(`FPEC_CTRL_OFS, 32'h65);
    // hv written without the latch bit drops hv, latch enable stays on
    wr(`FPEC_CTRL_OFS, 32'h03);
    rchk(`FPEC_CTRL_OFS, 32'h64);
    wr(`FPEC_CTRL_OFS, 32'h04);
    #1 chk(32'(hvApplied), 32'h0);
    rchk(`FPEC_STAT_OFS, 32'h1);
    mem[5] = mem[5] & int'(d);
    rchk(8'h86, 32'(mem[5]));
    wr(`FPEC_CTRL_OFS, 32'h08);
    check_all();
    // wait mode held across the enabling write: no pulse
    wr(`FPEC_CTRL_OFS, 32'h04);
    wr(8'h87, 32'h0000_0000);
    waitMode <= 1'b1;
    wr(`FPEC_CTRL_OFS, 32'h05);
    waitMode <= 1'b0;
    rchk(`FPEC_CTRL_OFS, 32'h64);
    wr(`FPEC_CTRL_OFS, 32'h08);
    check_all();
    // stop mode at the pulse edge: pulse suppressed, high voltage dropped
    op(7, 32'h0000_00F0, 1'b0, 1'b0);
    wr(`FPEC_CTRL_OFS, 32'h04);
    wr(8'h88, 32'h0000_0F0F);
    wr(`FPEC_CTRL_OFS, 32'h05);
    stopMode <= 1'b1;
    @(posedge ref_clk);
    stopMode <= 1'b0;
    @(posedge ref_clk);
    chk(32'(hvApplied), 32'h0);
    rchk(`FPEC_STAT_OFS, 32'h0);
    wr(`FPEC_CTRL_OFS, 32'h08);
    // no program supply: hv rises but no pulse reaches the cells
    progSupplyOk <= 1'b0;
    wr(`FPEC_CTRL_OFS, 32'h04);
    wr(8'h89, 32'h0000_0000);
    wr(`FPEC_CTRL_OFS, 32'h05);
    rchk(`FPEC_CTRL_OFS, 32'h25);
    rchk(`FPEC_STAT_OFS, 32'h0);
    wr(`FPEC_CTRL_OFS, 32'h04);
    wr(`FPEC_CTRL_OFS, 32'h08);
    progSupplyOk <= 1'b1;
    // boot block guarded, then erased only without protection
    op(60, 32'h0000_00A5, 1'b0, 1'b1);
    op(61, 32'h0000_5A00, 1'b0, 1'b0);
    check_all();
    op(0, 32'h0000_0000, 1'b1, 1'b1);
    check_all();
    op(3, 32'h0000_0000, 1'b1, 1'b0);
    check_all();
    // test register only lives in special mode
    wr(`FPEC_TEST_OFS, 32'hA5);
    #1 chk(32'(testBits), 32'h0);
    rchk(`FPEC_TEST_OFS, 32'h0);
    specialModeLine <= 1'b1;
    wr(`FPEC_TEST_OFS, 32'h5A);
    #1 chk(32'(testBits), 32'h5A);
    for (int k = 0; k < 3; k++) op($unsigned($random(seed)) % BOOT0, 32'($random(seed)), 1'b0, 1'b0);
    check_all();
    specialModeLine <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(32'(testBits), 32'h0);
    wr(`FPEC_CTRL_OFS, 32'h18);
    #1 chk(32'(wakeDelaySel), 32'h1);
    wr(`FPEC_CTRL_OFS, 32'h08);
    stop_test();
  end
endmodule

//--- verilog/fpec_arr_if.sv
// fpec_arr_if: carrier between the control logic and the flash array storage
// assumes: one clock domain, driven by the control module
`timescale 1ns/1ns
interface fpec_arr_if #(parameter int AW = 6, parameter int DW = 16);
  logic [AW-1:0] rdIdx; // location to read
  logic [DW-1:0] rdData; // data at rdIdx
  logic progPulse; // one-cycle program pulse
  logic erasePulse; // one-cycle erase pulse
  logic [AW-1:0] progIdx; // latched location
  logic [DW-1:0] progData; // latched data
  logic bootProt; // boot block protected
  modport ctl (output rdIdx, progPulse, erasePulse, progIdx, progData, bootProt, input rdData);
  modport arr (input rdIdx, progPulse, erasePulse, progIdx, progData, bootProt, output rdData);
endinterface

//--- verilog/fpec_array.sv
// fpec_array: flash cell storage, one flip-flop word per location
// assumes: pulses come from the control module only while high voltage is applied
`timescale 1ns/1ns
module fpec_array #(
  parameter int DEPTH = 64,
  parameter int BOOT_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rstN,
  fpec_arr_if.arr ai
);
  import fpec_pkg::*;
  localparam int AW = $bits(ai.rdIdx);
  localparam int DW = $bits(ai.rdData);

  // storage; the boot block is the top BOOT_DEPTH locations
  logic [DW-1:0] cell_r [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    localparam bit IN_BOOT = (i >= DEPTH - BOOT_DEPTH);
    // erase restores ones; program can only pull ones to zero
    always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
        cell_r[i] <= '1; // sim starts erased
      end else if (ai.bootProt && IN_BOOT) begin
        cell_r[i] <= cell_r[i]; // protected: neither erase nor program reaches it
      end else if (ai.erasePulse) begin
        cell_r[i] <= '1;
      end else if (ai.progPulse && ai.progIdx == AW'(i)) begin
        cell_r[i] <= cell_r[i] & ai.progData;
      end
    end
  end

  // read is plain combinational lookup
  assign ai.rdData = cell_r[ai.rdIdx];

  // a program pulse never sets a bit
  prog_ones_a: assert property (@(posedge ref_clk) disable iff (!rstN)
    ai.progPulse && !ai.erasePulse |=> ((cell_r[$past(ai.progIdx)] & ~$past(cell_r[ai.progIdx])) == '0))
    else $error("program pulse set a bit");
endmodule

//--- verilog/fpec_defs.svh
// fpec_defs.svh: register offsets, bit positions and reset values of the flash program/erase control
// assumes: included by the design files and the bench of this block only
`ifndef FPEC_DEFS_SVH
`define FPEC_DEFS_SVH

// word offsets on the register bus
`define FPEC_CTRL_OFS 8'h00
`define FPEC_TEST_OFS 8'h01
`define FPEC_STAT_OFS 8'h02
// array window: top address bit selects the array
`define FPEC_ARR_BIT 7

// control register bit positions
`define FPEC_HV_BIT 0
`define FPEC_ERS_BIT 1
`define FPEC_LAT_BIT 2
`define FPEC_BOOT_BIT 3
`define FPEC_DLY_BIT 4
`define FPEC_LVAL_BIT 5
`define FPEC_SUP_BIT 6

// reset values
`define FPEC_BOOT_RST 1'b1
`define FPEC_TEST_RST 8'h00
`define FPEC_CNT_RST 8'h00
`define FPEC_RD_RST 32'h0000_0000

`endif

//--- verilog/fpec_pkg.sv
// fpec_pkg: shared types of the flash program/erase control
// assumes: compiled before the interface and the modules
package fpec_pkg;
  // word address on the register bus
  typedef logic [7:0] fpec_addr_t;
  // bus answer phase
  typedef enum logic {FPEC_BUS_IDLE, FPEC_BUS_ACK} fpec_bus_t;
endpackage

//--- verilog/fpec_top.sv
// fpec_top: program/erase control of an on-chip flash array, Avalon-MM slave with waitrequest
// assumes: ref_clk 100 MHz, stop/wait/special-mode levels synchronous to ref_clk,
// software times every pulse and settle delay itself
//
// Behaviour
// - hv set ignored unless latches written
// - latch enable cannot clear while hv set
// - erase select frozen while hv set
// - boot block programming blocked when protected
// - bulk erase spares protected boot block
// - latches load only while latch enable
// - latch and hv need separate writes
// - high voltage only while hv set
// - stop or wait aborts operation immediately
// - test bits dead and cleared outside special
// - special mode alone changes nothing
// - array read result depends on control bits
// - further array writes ignored once latched
// - erased reads one; program only clears
`timescale 1ns/1ns
`include "fpec_defs.svh"
module fpec_top #(
  parameter int DEPTH = 64,
  parameter int BOOT_DEPTH = 8,
  parameter int DW = 16
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire fpec_pkg::fpec_addr_t avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic stopMode,
  input wire logic waitMode,
  input wire logic specialModeLine,
  input wire logic progSupplyOk,
  output logic hvApplied,
  output logic wakeDelaySel,
  output logic [7:0] testBits
);
  import fpec_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // reset release synchroniser
  logic rstMeta_r; // first stage, read only by the second
  logic rstN_r; // released reset used everywhere
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstN_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r <= rstMeta_r;
    end
  end

  // bus phase: every access gets exactly one wait cycle
  fpec_bus_t busSt_r;
  logic busReq; // read or write pending
  logic busAcc; // access completes this edge
  logic wrAcc; // write completes this edge
  assign busReq = avs_read | avs_write;
  assign busAcc = busReq && busSt_r == FPEC_BUS_ACK;
  assign wrAcc = busAcc && avs_write;
  assign avs_waitrequest = busReq && busSt_r != FPEC_BUS_ACK;

  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      busSt_r <= FPEC_BUS_IDLE;
    end else begin
      unique case (busSt_r)
        FPEC_BUS_IDLE: busSt_r <= busReq ? FPEC_BUS_ACK : FPEC_BUS_IDLE;
        FPEC_BUS_ACK: busSt_r <= FPEC_BUS_IDLE;
      endcase
    end
  end

  // address decode
  logic ctrlHit; // control register
  logic testHit; // test register
  logic statHit; // status register
  logic arrHit; // valid array location
  assign ctrlHit = avs_address == `FPEC_CTRL_OFS;
  assign testHit = avs_address == `FPEC_TEST_OFS;
  assign statHit = avs_address == `FPEC_STAT_OFS;
  assign arrHit = avs_address[`FPEC_ARR_BIT] && (32'(avs_address[`FPEC_ARR_BIT-1:0]) < 32'(DEPTH));

  // control bits
  logic hvEnable_r; // high voltage to array
  logic latEnable_r; // programming latches enabled
  logic eraseSel_r; // erase, not program
  logic bootProt_r; // boot block protected
  logic wakeDly_r; // wake delay select, steers nothing here but the pin
  logic latchedValid_r; // latches hold a write since latch enable rose
  logic abortReq; // stop or wait entered
  logic ctrlWr; // control write completes
  assign abortReq = stopMode | waitMode;
  assign ctrlWr = wrAcc && ctrlHit;

  // hv: set only with latches written and latch kept on; stop/wait win over all
  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      hvEnable_r <= 1'b0;
    end else if (abortReq) begin
      hvEnable_r <= 1'b0;
    end else if (ctrlWr) begin
      // a write that first sets latch enable finds latchedValid_r clear
      hvEnable_r <= avs_writedata[`FPEC_HV_BIT] && avs_writedata[`FPEC_LAT_BIT]
                    && latEnable_r && latchedValid_r;
    end
  end

  // latch, erase and boot bits are frozen while hv is set
  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      latEnable_r <= 1'b0;
      eraseSel_r <= 1'b0;
      bootProt_r <= `FPEC_BOOT_RST;
    end else if (ctrlWr && !hvEnable_r) begin
      latEnable_r <= avs_writedata[`FPEC_LAT_BIT];
      eraseSel_r <= avs_writedata[`FPEC_ERS_BIT];
      bootProt_r <= avs_writedata[`FPEC_BOOT_BIT];
    end
  end

  // wake delay select is writable any time
  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      wakeDly_r <= 1'b0;
    end else if (ctrlWr) begin
      wakeDly_r <= avs_writedata[`FPEC_DLY_BIT];
    end
  end

  // programming latches: first array write after latch enable, then frozen
  logic arrWr; // array write completes
  logic latchLoad; // that write loads the latches
  logic [AW-1:0] latAddr_r; // latched location
  logic [DW-1:0] latData_r; // latched data
  assign arrWr = wrAcc && arrHit;
  assign latchLoad = arrWr && latEnable_r && !latchedValid_r && !hvEnable_r;

  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      latAddr_r <= '0;
      latData_r <= '0;
    end else if (latchLoad) begin
      latAddr_r <= avs_address[AW-1:0];
      latData_r <= avs_writedata[DW-1:0];
    end
  end

  // valid flag drops as soon as latch enable is clear
  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      latchedValid_r <= 1'b0;
    end else if (!latEnable_r) begin
      latchedValid_r <= 1'b0;
    end else if (latchLoad) begin
      latchedValid_r <= 1'b1;
    end
  end

  // one pulse per hv rise; no supply or an abort means no pulse
  logic hvPrev_r; // hv one cycle ago
  logic pulseFire; // start of a program/erase pulse
  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      hvPrev_r <= 1'b0;
    end else begin
      hvPrev_r <= hvEnable_r;
    end
  end
  assign pulseFire = hvEnable_r && !hvPrev_r && progSupplyOk && !abortReq;

  // pulse counter lets software see how many pulses it applied
  logic [7:0] pulseCnt_r;
  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      pulseCnt_r <= `FPEC_CNT_RST;
    end else if (!latEnable_r) begin
      pulseCnt_r <= `FPEC_CNT_RST;
    end else if (pulseFire && pulseCnt_r != 8'hFF) begin
      pulseCnt_r <= pulseCnt_r + 8'h01; // saturates rather than wraps
    end
  end

  // test register: only reachable in special mode, cleared otherwise
  logic [7:0] testReg_r;
  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      testReg_r <= `FPEC_TEST_RST;
    end else if (!specialModeLine) begin
      testReg_r <= `FPEC_TEST_RST;
    end else if (wrAcc && testHit) begin
      testReg_r <= avs_writedata[7:0]; // no test function alters normal behaviour
    end
  end

  // array storage
  fpec_arr_if #(.AW(AW), .DW(DW)) arrBus ();
  logic rdLatched; // read returns the location being programmed
  assign rdLatched = latEnable_r && !eraseSel_r && latchedValid_r;
  assign arrBus.rdIdx = rdLatched ? latAddr_r : avs_address[AW-1:0];
  assign arrBus.progPulse = pulseFire && !eraseSel_r;
  assign arrBus.erasePulse = pulseFire && eraseSel_r;
  assign arrBus.progIdx = latAddr_r;
  assign arrBus.progData = latData_r;
  assign arrBus.bootProt = bootProt_r;

  fpec_array #(.DEPTH(DEPTH), .BOOT_DEPTH(BOOT_DEPTH)) u_array (
    .ref_clk(ref_clk),
    .rstN(rstN_r),
    .ai(arrBus)
  );

  // read data: captured in the wait cycle, held while the answer stands
  logic [31:0] rdMux;
  always_comb begin
    rdMux = `FPEC_RD_RST;
    if (ctrlHit) begin
      rdMux[`FPEC_HV_BIT] = hvEnable_r;
      rdMux[`FPEC_ERS_BIT] = eraseSel_r;
      rdMux[`FPEC_LAT_BIT] = latEnable_r;
      rdMux[`FPEC_BOOT_BIT] = bootProt_r;
      rdMux[`FPEC_DLY_BIT] = wakeDly_r;
      rdMux[`FPEC_LVAL_BIT] = latchedValid_r;
      rdMux[`FPEC_SUP_BIT] = progSupplyOk;
    end else if (testHit) begin
      rdMux = 32'(testReg_r);
    end else if (statHit) begin
      rdMux = 32'(pulseCnt_r);
    end else if (arrHit && !hvEnable_r) begin
      rdMux = 32'(arrBus.rdData); // hv set: read is ignored, returns zero
    end
  end

  logic [31:0] rdData_r;
  always_ff @(posedge ref_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      rdData_r <= `FPEC_RD_RST;
    end else if (avs_read && busSt_r == FPEC_BUS_IDLE) begin
      rdData_r <= rdMux;
    end
  end

  assign avs_readdata = rdData_r;
  assign hvApplied = hvEnable_r;
  assign wakeDelaySel = wakeDly_r;
  assign testBits = testReg_r;

  // checks
  sequence ctrlWrHv_s;
    ctrlWr && hvEnable_r && !abortReq;
  endsequence
  sequence firstLat_s;
    ctrlWr && !latEnable_r && avs_writedata[`FPEC_LAT_BIT];
  endsequence
  sequence rdHvTaken_s;
    avs_read && busSt_r == FPEC_BUS_IDLE && arrHit && hvEnable_r;
  endsequence

  hv_needs_latch_a: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    hvEnable_r |-> latEnable_r && latchedValid_r)
    else $error("hv set without latched data");
  lat_hold_a: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    ctrlWrHv_s |=> latEnable_r)
    else $error("latch enable cleared under hv");
  erase_hold_a: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    ctrlWrHv_s |=> $stable(eraseSel_r) && $stable(bootProt_r))
    else $error("erase select changed under hv");
  first_hv_a: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    firstLat_s |=> !hvEnable_r)
    else $error("hv set with first latch write");
  abort_hv_a: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    abortReq |=> !hvEnable_r && !$past(pulseFire))
    else $error("stop or wait did not abort");
  latch_gate_a: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    arrWr && !latEnable_r |=> $stable(latAddr_r) && $stable(latData_r))
    else $error("latches loaded without latch enable");
  latch_freeze_a: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    latchedValid_r && arrWr |=> $stable(latAddr_r) && $stable(latData_r))
    else $error("latches reloaded after capture");
  test_clear_a: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    !specialModeLine |=> testReg_r == `FPEC_TEST_RST)
    else $error("test bits set outside special mode");
  read_ignored_a: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    rdHvTaken_s ##1 avs_read |-> avs_readdata == `FPEC_RD_RST)
    else $error("array read under hv returned data");
  valid_drop_a: assert property (@(posedge ref_clk) disable iff (!rstN_r)
    !latEnable_r |=> !latchedValid_r)
    else $error("latched flag survived latch clear");
endmodule
